// [src/fail_cal_readout.sv]
// Functional notes
// R1: 0x00a1 byte 0 OTP-allowed, denied when sealed
// R2: 0x00a1 bytes 1-2 first unprogrammable address
// R3: 0xf081 offset 0 counter bumps each refresh
// R4: Offset 2 signed 32-bit secondary charge counts
// R5: Offset 6 pack-pin raw ADC count
// R6: Offset 8 stack count, offset 10 load-sense
// R7: 0xf090 undervolt trim, configuration-update mode only
// R8: 0xf091 overvolt trim, configuration-update mode only
// R9: Byte A bits 7,6,4 set; bit 5 reserved
// R10: Byte A bits 3..0 safety fail flags
// R11: Byte B bit 7,4,3 set; 6,5 reserved
// R12: Byte B bits 2..0 protector, switch fails
// R13: Byte C bits 7..4 command, mux, ground, reference
// R14: Byte C bits 3..0 oscillator, ROM, fuse fails
// R15: Fail checks disabled means no flag sets
// R16: Reserved bits zero, buffer writes ignored
`timescale 1ns/1ps
module fail_cal_readout
	import fail_cal_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic otp_write_allowed,
	input wire logic [15:0] otp_fail_addr,
	input wire logic cal_sample_valid,
	input wire logic [31:0] secondary_charge_counter,
	input wire logic [15:0] pack_counts,
	input wire logic [15:0] stack_counts,
	input wire logic [15:0] load_sense_pin,
	input wire logic [15:0] top_cell_counts,
	input wire logic [7:0] fail_event_a,
	input wire logic [7:0] fail_event_b,
	input wire logic [7:0] fail_event_c,
	output logic [15:0] cell_undervolt_threshold,
	output logic [15:0] cell_overvolt_threshold
);
	typedef enum logic [1:0] {IDLE, ADDR, DATA} bus_state_e;

	logic [7:0] fail_a_r;
	logic [7:0] fail_b_r;
	logic [7:0] fail_c_r;
	logic [3:0] mode_r;
	logic [15:0] cmd_r;
	logic done_r;
	logic refused_r;
	logic [15:0] sample_count_r;
	logic cmd_go_r;
	logic buf_wr;
	logic [BUF_BYTES*8-1:0] buf_nxt;
	logic [31:0] buf_rd;
	logic [7:0] a_addr_r;
	logic a_write_r;
	logic rd_phase_r;
	bus_state_e bus_st_r;
	logic [1:0] sec;
	logic fail_en;
	logic cfg_upd;
	logic addr_phase;

	assign sec = mode_r[MODE_SEC_LSB +: 2];
	assign cfg_upd = mode_r[MODE_CFG_UPDATE_BIT];
	assign fail_en = mode_r[MODE_FAIL_EN_BIT];
	assign addr_phase = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;

	function automatic logic in_buf(input logic [7:0] a);
		in_buf = a >= ADDR_BUF0 && a < ADDR_BUF0 + 8'(BUF_WORDS * 4);
	endfunction

	// Capture the address phase
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			a_addr_r <= 8'h00;
			a_write_r <= 1'b0;
		end
		else
		begin
			a_addr_r <= haddr;
			a_write_r <= addr_phase && hwrite;
		end
	end

	// Buffer reads take one wait state for the registered memory output.
	// The wait must show in the first data-phase cycle, so it is decided on the address phase.
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			hreadyout <= 1'b1;
			rd_phase_r <= 1'b0;
			bus_st_r <= IDLE;
		end
		else if (addr_phase && !hwrite && in_buf(haddr))
		begin
			hreadyout <= 1'b0;
			rd_phase_r <= 1'b1;
			bus_st_r <= DATA;
		end
		else
		begin
			hreadyout <= 1'b1;
			rd_phase_r <= 1'b0;
			case (bus_st_r)
				IDLE: bus_st_r <= addr_phase ? ADDR : IDLE;
				ADDR: bus_st_r <= IDLE;
				DATA: bus_st_r <= IDLE;
				default: bus_st_r <= IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// Read data is registered ahead of the data-phase edge
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			hrdata <= 32'h0000_0000;
		else if (addr_phase && !hwrite)
		begin
			case (haddr)
				ADDR_SUBCMD: hrdata <= {16'h0000, cmd_r};
				ADDR_STATUS: hrdata <= {16'h0000, cmd_r} << STAT_CMD_LSB |
					{30'h0, refused_r, done_r};
				ADDR_MODE: hrdata <= {28'h0, mode_r};
				ADDR_FAIL_A: hrdata <= {24'h0, fail_a_r & FAIL_A_MASK}; // [R16]
				ADDR_FAIL_B: hrdata <= {24'h0, fail_b_r & FAIL_B_MASK}; // [R16]
				ADDR_FAIL_C: hrdata <= {24'h0, fail_c_r & FAIL_C_MASK};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
		else if (rd_phase_r)
			hrdata <= buf_rd;
	end

	// Software-writable control; buffer and fail bytes ignore writes [R16]
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			mode_r <= MODE_RESET;
			cmd_r <= 16'h0000;
			cmd_go_r <= 1'b0;
		end
		else
		begin
			cmd_go_r <= 1'b0;
			if (a_write_r && a_addr_r == ADDR_MODE)
				mode_r <= hwdata[3:0];
			if (a_write_r && a_addr_r == ADDR_SUBCMD)
			begin
				cmd_r <= hwdata[15:0];
				cmd_go_r <= 1'b1;
			end
		end
	end

	// Sticky saved failure flags; gated by the enable, reserved bits masked
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			fail_a_r <= FAIL_RESET;
			fail_b_r <= FAIL_RESET;
			fail_c_r <= FAIL_RESET;
		end
		else if (fail_en) // [R15]
		begin
			fail_a_r <= fail_a_r | (fail_event_a & FAIL_A_MASK); // [R9] [R10]
			fail_b_r <= fail_b_r | (fail_event_b & FAIL_B_MASK); // [R11] [R12]
			fail_c_r <= fail_c_r | (fail_event_c & FAIL_C_MASK); // [R13] [R14]
		end
	end

	// Counter advances on every snapshot refresh
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			sample_count_r <= 16'h0000;
		else if (cal_sample_valid)
			sample_count_r <= sample_count_r + 16'h0001; // [R3]
	end

	// Threshold trim results; trims outside config-update are refused
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			cell_undervolt_threshold <= 16'h0000;
			cell_overvolt_threshold <= 16'h0000;
		end
		else if (cmd_go_r && cfg_upd && sec != SEC_SEALED)
		begin
			if (cmd_r == SUBCMD_UV_TRIM)
				cell_undervolt_threshold <= top_cell_counts; // [R7]
			if (cmd_r == SUBCMD_OV_TRIM)
				cell_overvolt_threshold <= top_cell_counts; // [R8]
		end
	end

	// Result buffer contents for the accepted subcommand
	always_comb
	begin
		buf_nxt = '0;
		buf_wr = 1'b0;
		if (cmd_go_r && sec != SEC_SEALED) // [R1]
		begin
			case (cmd_r)
				SUBCMD_OTP_WRITE:
				begin
					buf_wr = 1'b1;
					buf_nxt[OFS_OTP_RESULT*8 +: 8] = {7'h00, otp_write_allowed}; // [R1]
					buf_nxt[OFS_OTP_FAIL_ADDR*8 +: 16] = otp_fail_addr; // [R2]
				end
				SUBCMD_RAW_COUNTS:
				begin
					buf_wr = 1'b1;
					buf_nxt[OFS_SAMPLE_COUNT*8 +: 16] = sample_count_r; // [R3]
					buf_nxt[OFS_CHARGE_COUNTS*8 +: 32] = secondary_charge_counter; // [R4]
					buf_nxt[OFS_PACK_COUNTS*8 +: 16] = pack_counts; // [R5]
					buf_nxt[OFS_STACK_COUNTS*8 +: 16] = stack_counts; // [R6]
					buf_nxt[OFS_LOAD_COUNTS*8 +: 16] = load_sense_pin; // [R6]
				end
				SUBCMD_UV_TRIM, SUBCMD_OV_TRIM:
				begin
					buf_wr = cfg_upd; // [R7] [R8]
					buf_nxt[OFS_TRIM*8 +: 16] = top_cell_counts;
				end
				default:
				begin
					buf_wr = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			done_r <= 1'b0;
			refused_r <= 1'b0;
		end
		else if (cmd_go_r)
		begin
			done_r <= buf_wr;
			refused_r <= !buf_wr;
		end
	end

	result_buffer #(.NBYTES(BUF_BYTES)) u_buf (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.wr_en(buf_wr),
		.wr_data(buf_nxt),
		.rd_word(haddr[3:2]),
		.rd_data(buf_rd)
	);

	// Checks
	sealed_no_result_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R1]
		cmd_go_r && sec == SEC_SEALED |=> !done_r && refused_r)
		else $error("sealed subcommand produced a result");
	trim_mode_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R7]
		cmd_go_r && !cfg_upd && cmd_r == SUBCMD_UV_TRIM |=> $stable(cell_undervolt_threshold))
		else $error("undervolt trim taken outside config update");
	ov_trim_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R8]
		cmd_go_r && cfg_upd && sec != SEC_SEALED && cmd_r == SUBCMD_OV_TRIM
		|=> cell_overvolt_threshold == $past(top_cell_counts))
		else $error("overvolt trim not loaded");
	counter_step_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R3]
		cal_sample_valid |=> sample_count_r == $past(sample_count_r) + 16'h0001)
		else $error("sample counter did not step");
	fail_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R15]
		!fail_en |=> $stable(fail_a_r) && $stable(fail_b_r) && $stable(fail_c_r))
		else $error("fail flag changed while checks disabled");
	reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R16]
		fail_a_r[5] == 1'b0 && fail_b_r[6:5] == 2'b00)
		else $error("reserved fail bit set");
	copper_sticky_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R9]
		fail_en && fail_event_a[7] |=> fail_a_r[7] ##1 fail_a_r[7])
		else $error("copper fail flag not held");
	sticky_b_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R12]
		fail_en && fail_event_b[0] |=> fail_b_r[0])
		else $error("charge switch fail not recorded");
	sticky_c_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R14]
		fail_en && fail_event_c[0] |=> fail_c_r[0])
		else $error("fuse fail not recorded");
	one_wait_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // buffer read wait state
		bus_st_r == DATA |-> !hreadyout ##1 hreadyout)
		else $error("buffer read wait state not exactly one cycle");
	raw_cmd_c: cover property (@(posedge sys_clk) cmd_go_r && cmd_r == SUBCMD_RAW_COUNTS);
	otp_cmd_c: cover property (@(posedge sys_clk) cmd_go_r && cmd_r == SUBCMD_OTP_WRITE);
	trim_cmd_c: cover property (@(posedge sys_clk) cmd_go_r && cfg_upd && cmd_r == SUBCMD_UV_TRIM);
	buf_read_c: cover property (@(posedge sys_clk) rd_phase_r);
endmodule // fail_cal_readout

// [src/fail_cal_pkg.sv]
package fail_cal_pkg;
	localparam logic [15:0] SUBCMD_OTP_WRITE = 16'h00A1;
	localparam logic [15:0] SUBCMD_RAW_COUNTS = 16'hF081;
	localparam logic [15:0] SUBCMD_UV_TRIM = 16'hF090;
	localparam logic [15:0] SUBCMD_OV_TRIM = 16'hF091;
	// Register word addresses on the bus
	localparam logic [7:0] ADDR_SUBCMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h08;
	localparam logic [7:0] ADDR_FAIL_A = 8'h0C;
	localparam logic [7:0] ADDR_FAIL_B = 8'h10;
	localparam logic [7:0] ADDR_FAIL_C = 8'h14;
	localparam logic [7:0] ADDR_BUF0 = 8'h20;
	localparam int BUF_BYTES = 12;
	localparam int BUF_WORDS = 3;
	// Byte offsets inside the result buffer
	localparam int OFS_OTP_RESULT = 0;
	localparam int OFS_OTP_FAIL_ADDR = 1;
	localparam int OFS_SAMPLE_COUNT = 0;
	localparam int OFS_CHARGE_COUNTS = 2;
	localparam int OFS_PACK_COUNTS = 6;
	localparam int OFS_STACK_COUNTS = 8;
	localparam int OFS_LOAD_COUNTS = 10;
	localparam int OFS_TRIM = 0;
	// Security modes
	localparam logic [1:0] SEC_SEALED = 2'h0;
	localparam logic [1:0] SEC_UNSEALED = 2'h1;
	localparam logic [1:0] SEC_FULL = 2'h2;
	// Mode register fields
	localparam int MODE_SEC_LSB = 0;
	localparam int MODE_CFG_UPDATE_BIT = 2;
	localparam int MODE_FAIL_EN_BIT = 3;
	localparam logic [3:0] MODE_RESET = 4'h9;
	// Saved failure byte masks: reserved positions stay zero
	localparam logic [7:0] FAIL_A_MASK = 8'hDF;
	localparam logic [7:0] FAIL_B_MASK = 8'h9F;
	localparam logic [7:0] FAIL_C_MASK = 8'hFF;
	localparam logic [7:0] FAIL_RESET = 8'h00;
	// Status register fields
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_REFUSED_BIT = 1;
	localparam int STAT_CMD_LSB = 16;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// [src/result_buffer.sv]
`timescale 1ns/1ps
module result_buffer
	import fail_cal_pkg::*;
#(
	parameter int NBYTES = BUF_BYTES
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [NBYTES*8-1:0] wr_data,
	input wire logic [1:0] rd_word,
	output logic [31:0] rd_data
);
	logic [NBYTES*8-1:0] mem_r;

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			mem_r <= '0;
		else if (wr_en)
			mem_r <= wr_data;
	end

	// Registered read keeps the bus read path short
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			rd_data <= 32'h0000_0000;
		else if (rd_word < 2'(NBYTES / 4))
			rd_data <= mem_r[rd_word*32 +: 32];
		else
			rd_data <= 32'h0000_0000;
	end
endmodule // result_buffer

// [verification/meas_model.sv]
`timescale 1ns/1ps
module meas_model
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic refresh,
	input wire logic [31:0] raw,
	output logic cal_sample_valid,
	output logic [31:0] secondary_charge_counter,
	output logic [15:0] pack_counts,
	output logic [15:0] stack_counts,
	output logic [15:0] load_sense_pin
);
	// Counts change only together with the cal_sample_valid pulse, as a converter would
	always_ff @(posedge sys_clk)
	begin
		cal_sample_valid <= reset_n && refresh;
		if (!reset_n)
		begin
			secondary_charge_counter <= 32'h0;
			pack_counts <= 16'h0;
			stack_counts <= 16'h0;
			load_sense_pin <= 16'h0;
		end
		else if (refresh)
		begin
			secondary_charge_counter <= raw;
			pack_counts <= raw[15:0] ^ 16'hA5A5;
			stack_counts <= raw[31:16];
			load_sense_pin <= ~raw[15:0];
		end
	end
endmodule // meas_model

// [verification/fail_cal_readout_test.sv]
`timescale 1ns/1ps
module fail_cal_readout_test
	import fail_cal_pkg::*;
;
	logic sys_clk = 0, reset_n = 0, hsel = 0, hwrite = 0, refresh = 0;
	logic otp_write_allowed = 0, cal_sample_valid, hreadyout, hresp;
	logic [7:0] haddr = 0, fail_event_a = 0, fail_event_b = 0, fail_event_c = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 0;
	logic [31:0] hwdata = 0, hrdata, raw = 0, secondary_charge_counter, w, prev;
	logic [31:0] seed = 32'h900EA3AC;
	logic [15:0] otp_fail_addr = 0, top_cell_counts = 0, pack_counts, stack_counts;
	logic [15:0] load_sense_pin, cell_undervolt_threshold, cell_overvolt_threshold;
	logic [23:0] acc, ev;
	int fail_count = 0;
	int tests_run = 0;

	always #5 sys_clk = ~sys_clk;

	fail_cal_readout u_dut (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .otp_write_allowed,
		.otp_fail_addr, .cal_sample_valid, .secondary_charge_counter, .pack_counts,
		.stack_counts, .load_sense_pin, .top_cell_counts, .fail_event_a, .fail_event_b,
		.fail_event_c, .cell_undervolt_threshold, .cell_overvolt_threshold);

	meas_model u_meas (.sys_clk, .reset_n, .refresh, .raw, .cal_sample_valid,
		.secondary_charge_counter, .pack_counts, .stack_counts, .load_sense_pin);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Address phase held until hready, then data phase held until hready again
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		w = hrdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(w, e);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// Result buffer is valid one cycle after the write data edge
	task automatic cmd(input logic [15:0] c);
		xfer(1'b1, ADDR_SUBCMD, {16'h0, c});
		tick(3);
	endtask

	task automatic summarize();
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		tick(20000);
		fail_count++;
		summarize();
	end

	initial
	begin
		tick(5);
		reset_n <= 1'b1;
		rd_chk(ADDR_MODE, {28'h0, MODE_RESET});
		rd_chk(ADDR_FAIL_A, 32'h0);
		rd_chk(8'h40, 32'h0);
		$display("reset test done");

		for (int k = 0; k < 4; k++)
		begin
			raw <= xs();
			refresh <= 1'b1;
			tick(1);
			refresh <= 1'b0;
			tick(3);
			cmd(SUBCMD_RAW_COUNTS);
			xfer(1'b0, ADDR_BUF0, 32'h0);
			if (k > 0)
				chk({16'h0, w[15:0]}, {16'h0, prev[15:0] + 16'h1});
			prev = w;
			chk({16'h0, w[31:16]}, {16'h0, raw[15:0]});
			rd_chk(ADDR_BUF0 + 8'h4, {pack_counts, raw[31:16]});
			rd_chk(ADDR_BUF0 + 8'h8, {load_sense_pin, stack_counts});
		end
		$display("raw counts test done");

		for (int b = 0; b < 2; b++)
		begin
			otp_write_allowed <= b[0];
			otp_fail_addr <= 16'(xs());
			cmd(SUBCMD_OTP_WRITE);
			xfer(1'b0, ADDR_BUF0, 32'h0);
			chk({8'h0, w[23:0]}, {8'h0, otp_fail_addr, 7'h0, b[0]});
		end
		prev = w;
		xfer(1'b1, ADDR_MODE, 32'h8);
		otp_fail_addr <= ~otp_fail_addr;
		cmd(SUBCMD_OTP_WRITE);
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk({31'h0, w[1]}, 32'h1);
		rd_chk(ADDR_BUF0, prev);
		$display("otp test done");

		xfer(1'b1, ADDR_MODE, 32'h9);
		top_cell_counts <= 16'(xs());
		cmd(SUBCMD_UV_TRIM);
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk({31'h0, w[1]}, 32'h1);
		chk({16'h0, cell_undervolt_threshold}, 32'h0);
		xfer(1'b1, ADDR_MODE, 32'hD);
		for (int i = 0; i < 2; i++)
		begin
			top_cell_counts <= 16'(xs());
			cmd(i ? SUBCMD_OV_TRIM : SUBCMD_UV_TRIM);
			chk({16'h0, i ? cell_overvolt_threshold : cell_undervolt_threshold},
				{16'h0, top_cell_counts});
			xfer(1'b0, ADDR_BUF0, 32'h0);
			chk({16'h0, w[15:0]}, {16'h0, top_cell_counts});
		end
		$display("trim test done");

		xfer(1'b1, ADDR_MODE, 32'h1);
		{fail_event_a, fail_event_b, fail_event_c} <= 24'hFFFFFF;
		tick(1);
		{fail_event_a, fail_event_b, fail_event_c} <= 24'h0;
		rd_chk(ADDR_FAIL_A, 32'h0);
		rd_chk(ADDR_FAIL_C, 32'h0);
		xfer(1'b1, ADDR_MODE, 32'h9);
		acc = 24'h0;
		for (int j = 0; j < 12; j++)
		begin
			ev = (j == 11) ? 24'hFFFFFF : 24'(xs() & xs());
			acc |= ev & {FAIL_A_MASK, FAIL_B_MASK, FAIL_C_MASK};
			{fail_event_a, fail_event_b, fail_event_c} <= ev;
			tick(1);
			{fail_event_a, fail_event_b, fail_event_c} <= 24'h0;
			tick(2);
			xfer(1'b1, ADDR_FAIL_A, 32'h0);
			rd_chk(ADDR_FAIL_A, {24'h0, acc[23:16]});
			rd_chk(ADDR_FAIL_B, {24'h0, acc[15:8]});
			rd_chk(ADDR_FAIL_C, {24'h0, acc[7:0]});
		end
		$display("fail flag test done");
		summarize();
	end
endmodule // fail_cal_readout_test
